// >>> shared/rsc_pkg.sv
//**********************************************************************
// Purpose: constants for the remote sensor conversion configuration
// Assumes: 25 MHz main clock
// Notes: pointer values are byte codes seen on the two-wire link
//**********************************************************************
package rsc_pkg;
  // ****************************
  // register pointers
  // ****************************
  localparam logic [7:0] PTR_RATE_RD = 8'h04;
  localparam logic [7:0] PTR_RATE_WR = 8'h0A;
  localparam logic [7:0] PTR_TRIM = 8'h18;
  localparam logic [7:0] PTR_BETA = 8'h25;
  localparam logic [7:0] PTR_SRST = 8'hFC;
  // ****************************
  // reset values and codes
  // ****************************
  localparam logic [7:0] RATE_RST = 8'h07;
  localparam logic [7:0] RATE_TOP = 8'h06;
  localparam logic [2:0] RATE_MAX_CODE = 3'h7;
  localparam logic [7:0] TRIM_RST = 8'h00;
  localparam logic [3:0] BETA_RST = 4'h8;
  localparam logic [3:0] BETA_OFF = 4'h7;
  localparam logic [3:0] BETA_DIODE = 4'hF;
  localparam int BETA_AUTO_BIT = 3;
  localparam logic [7:0] GC_RESET = 8'h06;
  // ****************************
  // n-factor as milli-units times 300, and denominator base
  // ****************************
  localparam logic [18:0] NF_NUM_DIODE = 19'h49D40;
  localparam logic [18:0] NF_NUM_GND = 19'h493E0;
  localparam logic [9:0] NF_DEN_BASE = 10'h12C;
  // ****************************
  // timing
  // ****************************
  localparam int CLK_HZ = 25000000;
  localparam int T_CONV_FAST_US = 93000;
  localparam int T_CONV_SLOW_US = 126000;
  localparam int T_PERIOD_MAX_US = 125000;
  localparam int CONV_FAST_CYC = T_CONV_FAST_US * (CLK_HZ / 1000000);
  localparam int CONV_SLOW_CYC = T_CONV_SLOW_US * (CLK_HZ / 1000000);
  localparam int PERIOD_MAX_CYC = T_PERIOD_MAX_US * (CLK_HZ / 1000000);
  typedef enum logic [1:0] {
    RSC_IDLE = 2'b00,
    RSC_LOC = 2'b01,
    RSC_REM = 2'b10
  } rsc_eng_t;
endpackage

// >>> hw/rsc_top.sv
// Purpose: remote conversion config, rate sequencing, trim, soft reset
// Assumes: link side is a two-wire protocol engine on its own clock
// Notes: one request in flight across domains; busy_q shows it
//
// Operation
// - top beta bit: auto-detect sensor, pick range
// - code 0111: no detection, diode, no compensation
// - base n 1.008 diode/off, 1.000 grounded
// - auto grounded: readback 1000-1111, 126 ms
// - auto diode: readback 1111, 1.008, 93 ms
// - codes 0000-0110: manual range, 1.000, 93 ms
// - rate code doubles 0.0625 to 4; 7+ eight
// - trim signed byte, read/write, resets zero
// - effective n = base*300/(300-trim)
// - reset pointer write restores all, aborts, alarms
// - acknowledge general call address
// - general call byte 06 resets, else nothing
// - rate changes idle time only
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int CONV_FAST = rsc_pkg::CONV_FAST_CYC,
  parameter int CONV_SLOW = rsc_pkg::CONV_SLOW_CYC,
  parameter int PERIOD_MAX = rsc_pkg::PERIOD_MAX_CYC
) (
  // main clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // link side, on lclk
  input wire logic lclk,
  input wire logic wr_stb,
  input wire logic [7:0] wr_ptr,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic [7:0] rd_ptr,
  input wire logic gc_addr_stb,
  input wire logic gc_data_stb,
  input wire logic [7:0] gc_data,
  output logic [7:0] rd_data_q,
  output logic rd_valid_q,
  output logic busy_q,
  output logic gc_ack_q,
  // sensor front end, on mclk
  input wire logic det_gnd,
  input wire logic [2:0] det_range,
  output logic adc_run_q,
  output logic adc_remote_q,
  output logic beta_auto_q,
  output logic [2:0] beta_man_q,
  output logic [18:0] nf_num_q,
  output logic [9:0] nf_den_q,
  output logic alarm_clr_q
);
  import rsc_pkg::*;

  // **********************************************************************
  // link domain: request capture and answer
  // **********************************************************************
  logic req_q, is_wr_q, ack_s1_q, ack_s2_q, ack_s3_q, ack_q;
  logic [7:0] ptr_q, dat_q, rdh_q;
  wire gc_go = gc_data_stb && (gc_data == GC_RESET);
  wire issue = (wr_stb || rd_stb || gc_go) && !busy_q;
  wire ack_edge = ack_s2_q ^ ack_s3_q;

  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      req_q <= 1'b0;
      is_wr_q <= 1'b0;
      ptr_q <= 8'h00;
      dat_q <= 8'h00;
      busy_q <= 1'b0;
      gc_ack_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      {ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      gc_ack_q <= gc_addr_stb;
      rd_valid_q <= ack_edge && !is_wr_q;
      if (ack_edge && !is_wr_q) begin
        rd_data_q <= rdh_q;
      end
      if (issue) begin
        req_q <= ~req_q;
        busy_q <= 1'b1;
        is_wr_q <= !rd_stb || wr_stb;
        ptr_q <= wr_stb ? wr_ptr : (rd_stb ? rd_ptr : PTR_SRST);
        dat_q <= wr_data;
      end else if (ack_edge) begin
        busy_q <= 1'b0;
      end
    end
  end

  // **********************************************************************
  // main domain: request sync and register file
  // **********************************************************************
  logic req_s1_q, req_s2_q, req_s3_q;
  logic [7:0] rate_q, trim_q;
  logic [3:0] beta_q, det_code_q;
  logic det_seen_q;
  wire req_edge = req_s2_q ^ req_s3_q;
  wire do_wr = req_edge && is_wr_q;
  wire sw_rst = do_wr && (ptr_q == PTR_SRST);
  wire [3:0] beta_rd = (beta_q[BETA_AUTO_BIT] && det_seen_q) ? det_code_q : beta_q;
  wire [7:0] rd_mux = (ptr_q == PTR_RATE_RD) ? rate_q :
                      (ptr_q == PTR_TRIM) ? trim_q :
                      (ptr_q == PTR_BETA) ? {4'h0, beta_rd} : 8'h00;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
      ack_q <= 1'b0;
      rdh_q <= 8'h00;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      ack_q <= ack_q ^ req_edge;
      if (req_edge && !is_wr_q) begin
        rdh_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rate_q <= RATE_RST;
      trim_q <= TRIM_RST;
      beta_q <= BETA_RST;
    end else if (sw_rst) begin
      rate_q <= RATE_RST;
      trim_q <= TRIM_RST;
      beta_q <= BETA_RST;
    end else if (do_wr) begin
      if (ptr_q == PTR_RATE_WR) begin
        rate_q <= dat_q;
      end
      if (ptr_q == PTR_TRIM) begin
        trim_q <= dat_q;
      end
      if (ptr_q == PTR_BETA) begin
        beta_q <= dat_q[3:0];
      end
    end
  end

  // **********************************************************************
  // conversion sequencer
  // **********************************************************************
  rsc_eng_t st_q;
  logic [31:0] per_q, cnt_q;
  logic slow_q;
  wire [2:0] code3 = (rate_q > RATE_TOP) ? RATE_MAX_CODE : rate_q[2:0];
  wire [31:0] per_sel = 32'(PERIOD_MAX) << (RATE_MAX_CODE - code3);
  wire auto_on = beta_q[BETA_AUTO_BIT];
  wire gnd_now = auto_on && det_gnd;
  wire [3:0] det_now = det_gnd ? {1'b1, det_range} : BETA_DIODE;
  wire start = (st_q == RSC_IDLE) && (per_q == 32'h0);
  wire loc_done = (st_q == RSC_LOC) && (cnt_q == 32'h0);
  wire rem_time_slow = gnd_now;
  wire [9:0] den_now = NF_DEN_BASE - {{2{trim_q[7]}}, trim_q};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RSC_IDLE;
      per_q <= 32'h0;
      cnt_q <= 32'h0;
      slow_q <= 1'b0;
    end else if (sw_rst) begin
      st_q <= RSC_IDLE;
      per_q <= 32'h0;
      cnt_q <= 32'h0;
      slow_q <= 1'b0;
    end else begin
      if (start) begin
        per_q <= per_sel - 32'h1;
      end else if (per_q != 32'h0) begin
        per_q <= per_q - 32'h1;
      end
      unique case (st_q)
        RSC_IDLE: begin
          if (start) begin
            st_q <= RSC_LOC;
            cnt_q <= 32'(CONV_FAST) - 32'h1;
          end
        end
        RSC_LOC: begin
          if (loc_done) begin
            st_q <= RSC_REM;
            slow_q <= rem_time_slow;
            cnt_q <= (rem_time_slow ? 32'(CONV_SLOW) : 32'(CONV_FAST)) - 32'h1;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        RSC_REM: begin
          if (cnt_q == 32'h0) begin
            st_q <= RSC_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        default: st_q <= RSC_IDLE;
      endcase
    end
  end

  // **********************************************************************
  // front end settings, latched at each conversion start
  // **********************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      adc_run_q <= 1'b0;
      adc_remote_q <= 1'b0;
      beta_auto_q <= 1'b0;
      beta_man_q <= 3'h0;
      nf_num_q <= NF_NUM_DIODE;
      nf_den_q <= NF_DEN_BASE;
      alarm_clr_q <= 1'b0;
      det_seen_q <= 1'b0;
      det_code_q <= BETA_DIODE;
    end else begin
      alarm_clr_q <= sw_rst;
      if (sw_rst) begin
        det_seen_q <= 1'b0;
      end else if (loc_done && auto_on) begin
        det_seen_q <= 1'b1;
        det_code_q <= det_now;
      end else if (do_wr && ptr_q == PTR_BETA) begin
        det_seen_q <= 1'b0;
      end
      if (sw_rst) begin
        adc_run_q <= 1'b0;
        adc_remote_q <= 1'b0;
      end else if (start) begin
        adc_run_q <= 1'b1;
        adc_remote_q <= 1'b0;
        beta_auto_q <= 1'b0;
        nf_num_q <= NF_NUM_DIODE;
        nf_den_q <= NF_DEN_BASE;
      end else if (loc_done) begin
        adc_remote_q <= 1'b1;
        beta_auto_q <= auto_on;
        beta_man_q <= auto_on ? det_range : beta_q[2:0];
        nf_den_q <= den_now;
        if (gnd_now || (!auto_on && beta_q != BETA_OFF)) begin
          nf_num_q <= NF_NUM_GND;
        end else begin
          nf_num_q <= NF_NUM_DIODE;
        end
      end else if (st_q == RSC_REM && cnt_q == 32'h0) begin
        adc_run_q <= 1'b0;
        adc_remote_q <= 1'b0;
      end
    end
  end

  // **********************************************************************
  // checks
  // **********************************************************************
  sequence rem_begin_s;
    loc_done && !sw_rst;
  endsequence
  sequence manual_s;
    !auto_on && beta_q != BETA_OFF;
  endsequence

  srst_regs_a: assert property (@(posedge mclk) disable iff (!nrst)
    sw_rst |=> rate_q == RATE_RST && beta_q == BETA_RST)
    else $error("soft reset did not restore registers");
  trim_rst_a: assert property (@(posedge mclk) disable iff (!nrst)
    sw_rst |=> trim_q == TRIM_RST)
    else $error("trim not cleared by soft reset");
  srst_abort_a: assert property (@(posedge mclk) disable iff (!nrst)
    sw_rst |=> !adc_run_q && alarm_clr_q && st_q == RSC_IDLE)
    else $error("soft reset did not abort or release alarms");
  beta_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    rem_begin_s ##0 (beta_q == BETA_OFF)
    |=> !beta_auto_q && nf_num_q == NF_NUM_DIODE && !slow_q)
    else $error("disabled beta still compensated");
  auto_gnd_a: assert property (@(posedge mclk) disable iff (!nrst)
    rem_begin_s ##0 (auto_on && det_gnd)
    |=> beta_auto_q && nf_num_q == NF_NUM_GND && cnt_q == 32'(CONV_SLOW) - 32'h1)
    else $error("grounded sensor used wrong n-factor or time");
  auto_diode_a: assert property (@(posedge mclk) disable iff (!nrst)
    rem_begin_s ##0 (auto_on && !det_gnd)
    |=> nf_num_q == NF_NUM_DIODE && cnt_q == 32'(CONV_FAST) - 32'h1
        && det_code_q == BETA_DIODE)
    else $error("diode sensor detection handled wrongly");
  manual_a: assert property (@(posedge mclk) disable iff (!nrst)
    rem_begin_s ##0 manual_s
    |=> nf_num_q == NF_NUM_GND && beta_man_q == $past(beta_q[2:0]) && !slow_q)
    else $error("manual beta range not applied");
  readback_a: assert property (@(posedge mclk) disable iff (!nrst)
    auto_on && det_seen_q |-> beta_rd[3] == 1'b1)
    else $error("auto beta readback out of range");
  den_a: assert property (@(posedge mclk) disable iff (!nrst)
    rem_begin_s |=> nf_den_q == NF_DEN_BASE - {{2{$past(trim_q[7])}}, $past(trim_q)})
    else $error("effective n-factor denominator wrong");
  local_a: assert property (@(posedge mclk) disable iff (!nrst)
    adc_run_q && !adc_remote_q |-> nf_den_q == NF_DEN_BASE && nf_num_q == NF_NUM_DIODE)
    else $error("local conversion affected by remote settings");
  period_a: assert property (@(posedge mclk) disable iff (!nrst)
    start && !sw_rst |=> per_q == $past(per_sel) - 32'h1)
    else $error("conversion period not taken from rate code");
  gc_ack_a: assert property (@(posedge lclk) disable iff (!nrst)
    gc_addr_stb |=> gc_ack_q)
    else $error("general call not acknowledged");
  gc_ignore_a: assert property (@(posedge lclk) disable iff (!nrst)
    gc_data_stb && gc_data != GC_RESET && !wr_stb && !rd_stb && !busy_q |=> !busy_q)
    else $error("general call acted on wrong byte");
endmodule

// >>> test/rsc_host.sv
// Purpose: link-side controller stand-in issuing register requests
// Assumes: link clock free running while requests pend
// Notes: released pointer/data lines show the inverse of the last value
`timescale 1ns/1ps
module rsc_host (
  // link
  input wire logic lclk,
  input wire logic busy_q,
  input wire logic gc_ack_q,
  output logic wr_stb,
  output logic rd_stb,
  output logic [7:0] ptr,
  output logic [7:0] data,
  output logic gc_addr_stb,
  output logic gc_data_stb
);
  initial begin
    {wr_stb, rd_stb, gc_addr_stb, gc_data_stb} = 4'h0;
    ptr = 8'h00;
    data = 8'h00;
  end
  // kind 0 write, 1 read, 2 byte after general call
  task automatic req(input int kind, input logic [7:0] p, input logic [7:0] d);
    int n;
    @(posedge lclk) #1;
    ptr = p;
    data = d;
    wr_stb = (kind == 0);
    rd_stb = (kind == 1);
    gc_data_stb = (kind == 2);
    @(posedge lclk) #1;
    {wr_stb, rd_stb, gc_data_stb} = 3'h0;
    ptr = ~p;
    data = ~d;
    n = 0;
    while (busy_q === 1'b1 && n < 300) begin
      @(posedge lclk) #1;
      n++;
    end
  endtask
  task automatic call(output logic ack);
    @(posedge lclk) #1;
    gc_addr_stb = 1'b1;
    @(posedge lclk) #1;
    gc_addr_stb = 1'b0;
    ack = gc_ack_q;
  endtask
endmodule

// >>> test/remote_sensor_conversion_config_bench.sv
// Purpose: self-checking bench for the conversion configuration block
// Assumes: shortened conversion counts 20, 30 and period 100
// Notes: reads are noted in a queue and checked when answers appear
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module remote_sensor_conversion_config_bench;
  import rsc_pkg::*;
  logic mclk = 1'b0, lclk = 1'b0, nrst = 1'b0, det_gnd = 1'b0, ack, clr_seen = 1'b0;
  logic [2:0] det_range = 3'h0, beta_man_q;
  logic wr_stb, rd_stb, gc_addr_stb, gc_data_stb, rd_valid_q, busy_q, gc_ack_q;
  logic adc_run_q, adc_remote_q, beta_auto_q, alarm_clr_q;
  logic [7:0] ptr, data, rd_data_q;
  logic [18:0] nf_num_q;
  logic [9:0] nf_den_q;
  logic [15:0] lfsr_q = 16'h44F4;
  logic [7:0] exp_q[$];
  int err_count = 0, num_checks = 0, cyc = 0, rem, per, rem_slow;
  always #20 mclk = ~mclk;
  always #3 lclk = ~lclk;
  rsc_top #(.CONV_FAST(20), .CONV_SLOW(30), .PERIOD_MAX(100)) i_dut (
    .mclk(mclk), .nrst(nrst), .lclk(lclk), .wr_stb(wr_stb), .wr_ptr(ptr),
    .wr_data(data), .rd_stb(rd_stb), .rd_ptr(ptr), .gc_addr_stb(gc_addr_stb),
    .gc_data_stb(gc_data_stb), .gc_data(data), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .busy_q(busy_q), .gc_ack_q(gc_ack_q), .det_gnd(det_gnd),
    .det_range(det_range), .adc_run_q(adc_run_q), .adc_remote_q(adc_remote_q),
    .beta_auto_q(beta_auto_q), .beta_man_q(beta_man_q), .nf_num_q(nf_num_q),
    .nf_den_q(nf_den_q), .alarm_clr_q(alarm_clr_q));
  rsc_host i_host (.lclk(lclk), .busy_q(busy_q), .gc_ack_q(gc_ack_q), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .ptr(ptr), .data(data), .gc_addr_stb(gc_addr_stb),
    .gc_data_stb(gc_data_stb));
  // ****************************
  // watchers
  // ****************************
  always @(posedge lclk) if (rd_valid_q === 1'b1) begin
    if (exp_q.size() == 0) `CHK(rd_valid_q, 1'b0)
    else `CHK(rd_data_q, exp_q.pop_front())
  end
  always @(posedge mclk) begin
    cyc++;
    if (alarm_clr_q === 1'b1) clr_seen = 1'b1;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end
  // ****************************
  // helpers
  // ****************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic sig(input int s);
    return s ? adc_remote_q : adc_run_q;
  endfunction
  task automatic hold(input int s, input logic v, output int n);
    n = 0;
    while (sig(s) !== v && n < 1000) begin
      @(posedge mclk) #1;
      n++;
    end
    if (n >= 1000) err_count++;
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.req(1, p, 8'h00);
  endtask
  // one conversion with given beta code, sensor kind and range
  task automatic conv(input logic [3:0] b, input logic g, input logic [2:0] r,
      input logic [18:0] num);
    logic [7:0] t;
    int n, t0;
    t = lfsr_q[7:0];
    lfsr_q = lfsr_next(lfsr_q);
    i_host.req(0, PTR_TRIM, t);
    i_host.req(0, PTR_BETA, {4'h0, b});
    @(posedge mclk) #1;
    det_gnd = g;
    det_range = r;
    hold(0, 1'b0, n);
    hold(0, 1'b1, n);
    t0 = cyc;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(nf_den_q, 10'h12C)
    hold(1, 1'b1, n);
    `CHK(nf_num_q, num)
    `CHK(nf_den_q, 10'h12C - {{2{t[7]}}, t})
    `CHK(beta_auto_q, b[3])
    if (b[3] ? g : (b != 4'h7)) `CHK(beta_man_q, b[3] ? r : b[2:0])
    hold(1, 1'b0, rem);
    hold(0, 1'b0, n);
    hold(0, 1'b1, n);
    per = cyc - t0;
    rd(PTR_BETA, b[3] ? (g ? {5'h01, r} : 8'h0F) : {4'h0, b});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial begin
    repeat (2) @(posedge mclk);
    #1 nrst = 1'b1;
    rd(PTR_RATE_RD, RATE_RST);
    rd(PTR_TRIM, TRIM_RST);
    rd(PTR_BETA, {4'h0, BETA_RST});
    rd(PTR_SRST, 8'h00);
    rd(8'h33, 8'h00);
    i_host.call(ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < 4; i++) begin
      i_host.req(0, PTR_RATE_WR, {4'h0, lfsr_q[3:0]});
      rd(PTR_RATE_RD, {4'h0, lfsr_q[3:0]});
      lfsr_q = lfsr_next(lfsr_q);
    end
    i_host.req(0, PTR_RATE_WR, 8'h0F);
    conv(4'h0, 1'b1, 3'h3, NF_NUM_GND);
    conv(4'h6, 1'b0, 3'h1, NF_NUM_GND);
    conv(4'h7, 1'b1, 3'h5, NF_NUM_DIODE);
    conv(4'h8, 1'b0, 3'h2, NF_NUM_DIODE);
    `CHK(per, 100)
    rem_slow = rem;
    conv(4'hB, 1'b1, 3'h6, NF_NUM_GND);
    `CHK(rem - rem_slow, 10)
    `CHK(per, 100)
    i_host.req(0, PTR_RATE_WR, 8'h06);
    conv(4'hC, 1'b1, 3'h1, NF_NUM_GND);
    `CHK(per, 200)
    `CHK(rem, 30)
    i_host.req(0, PTR_RATE_WR, 8'h05);
    conv(4'h3, 1'b0, 3'h4, NF_NUM_GND);
    `CHK(per, 400)
    `CHK(rem, 20)
    i_host.req(0, PTR_SRST, lfsr_q[7:0]);
    repeat (4) @(posedge mclk);
    `CHK(clr_seen, 1'b1)
    rd(PTR_RATE_RD, RATE_RST);
    rd(PTR_BETA, {4'h0, BETA_RST});
    i_host.req(0, PTR_TRIM, 8'h5A);
    i_host.call(ack);
    i_host.req(2, 8'h00, 8'h05);
    rd(PTR_TRIM, 8'h5A);
    i_host.call(ack);
    i_host.req(2, 8'h00, GC_RESET);
    rd(PTR_TRIM, TRIM_RST);
    repeat (20) @(posedge lclk);
    `CHK(exp_q.size(), 0)
    end_of_test();
  end
endmodule
